// file: hdl/mpo_pkg.sv
package mpo_pkg;
  // clock and sample timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SAMPLE_CYCLES = 2048;
  localparam int SAMPLE_W = 11;
  localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = SAMPLE_W'(SAMPLE_CYCLES - 1);
  // busy hold time, rounded down to whole cycles
  localparam int BUSY_TIME_NS = 15000;
  localparam int BUSY_TIME_PS = BUSY_TIME_NS * 1000;
  localparam int BUSY_W = 12;
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(BUSY_TIME_PS / CLK_PERIOD_PS);
  // pwm: four periods of 128 steps per sample
  localparam int PWM_PERIODS = 4;
  localparam int PWM_STEPS = 128;
  localparam int PWM_STEP_CYCLES = SAMPLE_CYCLES / (PWM_PERIODS * PWM_STEPS);
  localparam int PWM_PH_LSB = $clog2(PWM_STEP_CYCLES);
  localparam int PWM_PH_MSB = PWM_PH_LSB + $clog2(PWM_STEPS) - 1;
  // multiplexed dac strobe low time
  localparam logic [2:0] STROBE_CYCLES = 3'h4;
  // status byte fields
  localparam int ST_BUSY = 0;
  localparam int ST_WRAP = 4;
  // fixed point layout
  localparam int FRAC_W = 16;
  localparam int POS_W = 48;
  localparam int VEL_W = 32;
  localparam int WRAP_BIT = FRAC_W + 30;
  // offset binary zero codes
  localparam logic [7:0] DAC8_ZERO = 8'h80;
  localparam logic [11:0] DAC12_ZERO = 12'h800;
  // command bytes
  localparam logic [7:0] LOAD_TRAJECTORY_CMD = 8'h21;
  localparam logic [7:0] TWELVE_BIT_PORT_CMD = 8'h22;
  localparam logic [7:0] READ_DESIRED_POS_CMD = 8'h23;
  localparam logic [7:0] CLEAR_WRAP_CMD = 8'h24;
  // trajectory control word bits
  localparam int TC_FWD = 12;
  localparam int TC_VMODE = 11;
  localparam int TC_SSTOP = 10;
  localparam int TC_ASTOP = 9;
  localparam int TC_OFF = 8;
  localparam int TC_LD_ACC = 5;
  localparam int TC_LD_VEL = 3;
  localparam int TC_LD_POS = 1;
  typedef enum logic [1:0] {PR_IDLE, PR_ACCEL, PR_CRUISE, PR_DECEL} mpo_prof_t;
  typedef enum logic [1:0] {HK_CMD, HK_WR, HK_RD} mpo_kind_t;
  typedef enum logic [1:0] {DX_IDLE, DX_LO, DX_HI} mpo_dx_t;
endpackage

// file: hdl/mpo_core.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - position in counts, sample is 2048 clocks
// - accelerate, note distance, decelerate symmetrically
// - skip cruise when deceleration point reached
// - accel into velocity, velocity into position
// - 32.16 position, integer part goes out
// - bit 31 sign, bit 30 wraparound
// - wraparound sets status bit 4
// - velocity, acceleration unsigned 15.16 fixed point
// - velocity mode runs until stop request
// - 8-bit output after reset, held per sample
// - 12-bit mode sends two 6-bit words
// - active low strobe, rising edge latches
// - offset binary, zero 80 or 800
// - pwm sign plus magnitude, off holds low
// - duty 1..127/128 positive, 128/128 negative
// - four pwm periods per sample
// - status read, busy in bit 0
// - port select low command, high data
// - data words move high byte first
// - commands ignored while busy
// - busy set after strobe, held about 15 us
module mpo_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic port_select_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic [11:0] drive_i,
  output logic [31:0] desired_pos_o,
  output logic sample_tick_o,
  output logic [7:0] dac_data_o,
  output logic dac_word_sel_o,
  output logic dac_strobe_n_o,
  output logic pwm_sign_o,
  output logic pwm_mag_o
);
  import mpo_pkg::*;

  // sample timer: one tick per 2048 clocks
  logic [SAMPLE_W-1:0] samp_cnt_r;
  logic tick;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      samp_cnt_r <= '0;
    end else begin
      samp_cnt_r <= samp_cnt_r + 1'b1;
    end
  end
  assign tick = (samp_cnt_r == SAMPLE_LAST);
  assign sample_tick_o = tick;

  // host strobe edges; chip select qualifies both strobes
  logic wr_act, rd_act, wr_act_r, rd_act_r, ps_hold_r;
  logic [7:0] wr_byte_r;
  assign wr_act = ~cs_n_i & ~wr_n_i;
  assign rd_act = ~cs_n_i & ~rd_n_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_act_r <= 1'b0;
      rd_act_r <= 1'b0;
      ps_hold_r <= 1'b0;
      wr_byte_r <= 8'h00;
    end else begin
      wr_act_r <= wr_act;
      rd_act_r <= rd_act;
      if (wr_act | rd_act) begin
        ps_hold_r <= port_select_n_i;
      end
      if (wr_act) begin
        wr_byte_r <= host_data_i;
      end
    end
  end
  logic cmd_wr, dat_wr, dat_rd, dat_any;
  assign cmd_wr = wr_act_r & ~wr_act & ~ps_hold_r;
  assign dat_wr = wr_act_r & ~wr_act & ps_hold_r;
  assign dat_rd = rd_act_r & ~rd_act & ps_hold_r;

  assign dat_any = dat_wr | dat_rd;

  // busy timer and byte pairing
  logic [BUSY_W-1:0] busy_cnt_r;
  logic byte_phase_r, busy, done, pair_done, cmd_ok;
  mpo_kind_t kind_r;
  logic [7:0] cmd_r;
  assign busy = (busy_cnt_r != '0);
  assign done = (busy_cnt_r == BUSY_W'(1));
  assign pair_done = dat_any & byte_phase_r;
  assign cmd_ok = cmd_wr & ~busy;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_r <= '0;
      byte_phase_r <= 1'b0;
      kind_r <= HK_CMD;
      cmd_r <= 8'h00;
    end else begin
      if (cmd_ok | pair_done) begin
        busy_cnt_r <= BUSY_LOAD;
      end else if (busy) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
      if (cmd_ok) begin
        byte_phase_r <= 1'b0;
        kind_r <= HK_CMD;
        cmd_r <= wr_byte_r;
      end else if (dat_any) begin
        byte_phase_r <= ~byte_phase_r;
        if (pair_done) begin
          kind_r <= dat_wr ? HK_WR : HK_RD;
        end
      end
    end
  end

  // trajectory state, declared early for the host side
  mpo_prof_t prof_r, prof_nxt;
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic [VEL_W-1:0] vel_r, vel_nxt, acc_r, vtgt_r;
  logic [31:0] ptgt_r, dist_r, start_r, pos_int, rem, travel;
  logic dir_r, vmode_r, off_r, wrap_flag_r, twelve_r;

  // io byte registers and load sequencer
  logic [7:0] io_hi_r, io_lo_r;
  logic [15:0] rd_next_r, ctl_r, word;
  logic [2:0] ld_mask_r;
  logic ld_half_r, in_ctl_r, in_words_r, apply;
  logic [VEL_W-1:0] sh_acc_r, sh_vel_r;
  logic [31:0] sh_pos_r;
  assign word = {io_hi_r, io_lo_r};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      io_hi_r <= 8'h00;
      io_lo_r <= 8'h00;
      rd_next_r <= 16'h0000;
      ctl_r <= 16'h0000;
      ld_mask_r <= 3'h0;
      ld_half_r <= 1'b0;
      in_ctl_r <= 1'b0;
      in_words_r <= 1'b0;
      apply <= 1'b0;
      sh_acc_r <= '0;
      sh_vel_r <= '0;
      sh_pos_r <= '0;
      twelve_r <= 1'b0;
    end else begin
      apply <= 1'b0;
      // host bytes land high first, then low
      if (dat_wr & ~byte_phase_r) begin
        io_hi_r <= wr_byte_r;
      end else if (dat_wr) begin
        io_lo_r <= wr_byte_r;
      end
      if (done && kind_r == HK_CMD) begin
        in_ctl_r <= 1'b0;
        in_words_r <= 1'b0;
        unique case (cmd_r)
          LOAD_TRAJECTORY_CMD: in_ctl_r <= 1'b1;
          TWELVE_BIT_PORT_CMD: twelve_r <= 1'b1;
          READ_DESIRED_POS_CMD: begin
            {io_hi_r, io_lo_r} <= pos_int[31:16];
            rd_next_r <= pos_int[15:0];
          end
          default: ;
        endcase
      end else if (done && kind_r == HK_RD) begin
        // reads during busy simply see the old buffer
        {io_hi_r, io_lo_r} <= rd_next_r;
      end else if (done && kind_r == HK_WR && in_ctl_r) begin
        ctl_r <= word;
        in_ctl_r <= 1'b0;
        ld_mask_r <= {word[TC_LD_ACC], word[TC_LD_VEL], word[TC_LD_POS]};
        ld_half_r <= 1'b0;
        in_words_r <= word[TC_LD_ACC] | word[TC_LD_VEL] | word[TC_LD_POS];
        apply <= ~(word[TC_LD_ACC] | word[TC_LD_VEL] | word[TC_LD_POS]);
      end else if (done && kind_r == HK_WR && in_words_r) begin
        // words arrive acceleration, velocity, position, each high word first
        ld_half_r <= ~ld_half_r;
        if (ld_mask_r[2]) begin
          if (ld_half_r) sh_acc_r[15:0] <= word;
          else sh_acc_r[31:16] <= word;
        end else if (ld_mask_r[1]) begin
          if (ld_half_r) sh_vel_r[15:0] <= word;
          else sh_vel_r[31:16] <= word;
        end else if (ld_half_r) begin
          sh_pos_r[15:0] <= word;
        end else begin
          sh_pos_r[31:16] <= word;
        end
        if (ld_half_r) begin
          if (ld_mask_r[2]) ld_mask_r[2] <= 1'b0;
          else if (ld_mask_r[1]) ld_mask_r[1] <= 1'b0;
          else ld_mask_r[0] <= 1'b0;
          if (ld_mask_r[2] ? (ld_mask_r[1:0] == 2'h0) : (ld_mask_r[1] ? ~ld_mask_r[0] : 1'b1)) begin
            in_words_r <= 1'b0;
            apply <= 1'b1;
          end
        end
      end
    end
  end

  // status byte and host read data, registered
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_data_o <= 8'h00;
    end else if (~port_select_n_i) begin
      host_data_o <= 8'h00;
      host_data_o[ST_BUSY] <= busy;
      host_data_o[ST_WRAP] <= wrap_flag_r;
    end else begin
      host_data_o <= byte_phase_r ? io_lo_r : io_hi_r;
    end
  end
  assign host_data_oe_o = rd_act;

  // profile arithmetic for the next sample
  assign pos_int = pos_r[POS_W-1:FRAC_W];
  assign rem = dir_r ? (ptgt_r - pos_int) : (pos_int - ptgt_r);
  assign travel = dir_r ? (pos_int - start_r) : (start_r - pos_int);
  always_comb begin
    prof_nxt = prof_r;
    vel_nxt = vel_r;
    unique case (prof_r)
      PR_IDLE: vel_nxt = '0;
      PR_ACCEL: begin
        vel_nxt = vel_r + acc_r;
        if (vel_nxt >= vtgt_r) begin
          vel_nxt = vtgt_r;
          prof_nxt = PR_CRUISE;
        end
        if (!vmode_r && $signed(rem) <= $signed(travel)) begin
          prof_nxt = PR_DECEL;
        end
      end
      PR_CRUISE: begin
        if (!vmode_r && $signed(rem) <= $signed(dist_r)) begin
          prof_nxt = PR_DECEL;
        end
      end
      PR_DECEL: begin
        if (vel_r <= acc_r) begin
          vel_nxt = '0;
          prof_nxt = PR_IDLE;
        end else begin
          vel_nxt = vel_r - acc_r;
        end
      end
    endcase
    // position mode never steps past its target; the last step lands on it
    if (!vmode_r && prof_r != PR_IDLE &&
        $signed(rem) <= $signed({{FRAC_W{1'b0}}, vel_nxt[VEL_W-1:FRAC_W]})) begin
      vel_nxt = '0;
      prof_nxt = PR_IDLE;
    end
    // position mode snaps to the target on its last step; otherwise the new velocity moves position
    if (prof_nxt == PR_IDLE && prof_r != PR_IDLE && !vmode_r) begin
      pos_nxt = {ptgt_r, FRAC_W'(0)};
    end else if (dir_r) begin
      pos_nxt = pos_r + {FRAC_W'(0), vel_nxt};
    end else begin
      pos_nxt = pos_r - {FRAC_W'(0), vel_nxt};
    end
  end

  // trajectory registers: host updates, else one step per sample
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prof_r <= PR_IDLE;
      pos_r <= '0;
      vel_r <= '0;
      acc_r <= '0;
      vtgt_r <= '0;
      ptgt_r <= '0;
      dist_r <= '0;
      start_r <= '0;
      dir_r <= 1'b1;
      vmode_r <= 1'b0;
      off_r <= 1'b1;
    end else if (apply) begin
      if (ctl_r[TC_OFF]) begin
        off_r <= 1'b1;
        vel_r <= '0;
        prof_r <= PR_IDLE;
      end else if (ctl_r[TC_ASTOP]) begin
        vel_r <= '0;
        prof_r <= PR_IDLE;
      end else if (ctl_r[TC_SSTOP]) begin
        if (prof_r != PR_IDLE) prof_r <= PR_DECEL;
      end else begin
        off_r <= 1'b0;
        vmode_r <= ctl_r[TC_VMODE];
        dir_r <= ctl_r[TC_VMODE] ? ctl_r[TC_FWD] : ($signed(sh_pos_r) >= $signed(pos_int));
        acc_r <= {1'b0, sh_acc_r[VEL_W-2:0]};
        vtgt_r <= {1'b0, sh_vel_r[VEL_W-2:0]};
        ptgt_r <= sh_pos_r;
        start_r <= pos_int;
        dist_r <= '0;
        prof_r <= PR_ACCEL;
      end
    end else if (tick) begin
      prof_r <= prof_nxt;
      vel_r <= vel_nxt;
      pos_r <= pos_nxt;
      if (prof_r == PR_ACCEL) begin
        dist_r <= travel;
      end
    end
  end
  assign desired_pos_o = pos_int;

  // wraparound event, sticky until cleared; setting wins
  logic wrap_ev;
  assign wrap_ev = tick && !apply && (dir_r ? (~pos_r[WRAP_BIT] & pos_nxt[WRAP_BIT])
                                            : (pos_r[WRAP_BIT] & ~pos_nxt[WRAP_BIT]));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wrap_flag_r <= 1'b0;
    end else if (wrap_ev) begin
      wrap_flag_r <= 1'b1;
    end else if (done && kind_r == HK_CMD && cmd_r == CLEAR_WRAP_CMD) begin
      wrap_flag_r <= 1'b0;
    end
  end

  // drive sampled once per sample; motor off forces zero drive
  // codes come from the value being captured, so both words of one sample agree
  logic [11:0] drv_r, drv_nxt, code12, code12_r;
  logic [7:0] code8;
  assign drv_nxt = off_r ? 12'h000 : drive_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      drv_r <= 12'h000;
    end else if (tick) begin
      drv_r <= drv_nxt;
    end
  end
  assign code12 = drv_nxt ^ DAC12_ZERO;
  assign code12_r = drv_r ^ DAC12_ZERO;
  assign code8 = drv_nxt[11:4] ^ DAC8_ZERO;

  // dac port: 8-bit word held, or two strobed 6-bit words
  mpo_dx_t dx_r;
  logic [2:0] dx_cnt_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dx_r <= DX_IDLE;
      dx_cnt_r <= 3'h0;
      dac_data_o <= DAC8_ZERO;
      dac_word_sel_o <= 1'b0;
      dac_strobe_n_o <= 1'b1;
    end else if (tick && !twelve_r) begin
      dac_data_o <= code8;
    end else if (tick) begin
      dx_r <= DX_LO;
      dx_cnt_r <= 3'h0;
      dac_data_o <= {2'h0, code12[5:0]};
      dac_word_sel_o <= 1'b0;
    end else if (dx_r != DX_IDLE) begin
      // data is set a cycle before the strobe and held past its rise
      dx_cnt_r <= dx_cnt_r + 1'b1;
      dac_strobe_n_o <= (dx_cnt_r >= STROBE_CYCLES);
      if (dx_cnt_r == STROBE_CYCLES + 3'h1) begin
        dx_cnt_r <= 3'h0;
        if (dx_r == DX_LO) begin
          dx_r <= DX_HI;
          dac_data_o <= {2'h0, code12_r[11:6]};
          dac_word_sel_o <= 1'b1;
        end else begin
          dx_r <= DX_IDLE;
        end
      end
    end
  end

  // pwm: phase from the sample counter gives four periods per sample
  logic [6:0] pwm_ph;
  logic [7:0] duty;
  assign pwm_ph = samp_cnt_r[PWM_PH_MSB:PWM_PH_LSB];
  assign duty = drv_r[11] ? (8'h00 - drv_r[11:4]) : drv_r[11:4];
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_sign_o <= 1'b0;
      pwm_mag_o <= 1'b0;
    end else begin
      pwm_sign_o <= drv_r[11];
      pwm_mag_o <= !off_r && ({1'b0, pwm_ph} < duty);
    end
  end

  // checks
  logic [BUSY_W-1:0] busy_age_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) busy_age_r <= '0;
    else if (!busy) busy_age_r <= '0;
    else if (!(cmd_ok | pair_done)) busy_age_r <= busy_age_r + 1'b1;
  end
  property p_busy_len;
    @(posedge clk_i) disable iff (rst_i) $fell(busy) |-> busy_age_r == BUSY_LOAD;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy hold time wrong");
  property p_cmd_ignored;
    @(posedge clk_i) disable iff (rst_i) cmd_wr && busy && !pair_done |=> busy_cnt_r == $past(busy_cnt_r) - 1'b1;
  endproperty
  a_cmd_ignored: assert property (p_cmd_ignored) else $error("command taken while busy");
  property p_pos_per_sample;
    @(posedge clk_i) disable iff (rst_i) !tick |=> $stable(pos_r);
  endproperty
  a_pos_per_sample: assert property (p_pos_per_sample) else $error("position moved off sample");
  property p_accel_add;
    @(posedge clk_i) disable iff (rst_i)
      tick && !apply && prof_r == PR_ACCEL && (vel_r + acc_r) < vtgt_r |=> vel_r == $past(vel_r) + $past(acc_r);
  endproperty
  a_accel_add: assert property (p_accel_add) else $error("velocity not accelerated");
  property p_wrap_flag;
    @(posedge clk_i) disable iff (rst_i) wrap_ev |=> wrap_flag_r ##1 host_data_o[ST_WRAP] || port_select_n_i;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wraparound not flagged");
  property p_dac_hold;
    @(posedge clk_i) disable iff (rst_i) !twelve_r && !tick |=> $stable(dac_data_o);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac word changed mid sample");
  property p_strobe_rise;
    @(posedge clk_i) disable iff (rst_i) $rose(dac_strobe_n_o) |-> $stable(dac_data_o) && $stable(dac_word_sel_o);
  endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("dac word moved at strobe rise");
  property p_off_low;
    @(posedge clk_i) disable iff (rst_i) off_r [*2] |=> !pwm_mag_o;
  endproperty
  a_off_low: assert property (p_off_low) else $error("pwm magnitude high while off");
endmodule
`default_nettype wire

// file: tb/mpo_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host controller on the byte port; every pin moves just after a falling edge
module mpo_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic port_select_n_o,
  output logic [7:0] wdata_o
);
  logic stuck = 1'b0;
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    port_select_n_o = 1'b1;
    wdata_o = 8'h00;
  end
  // one strobe; select low means status or command, high means data
  task automatic strobe(input logic rd, input logic ps_n, input logic [7:0] b,
                        output logic [7:0] r);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    port_select_n_o = ps_n;
    rd_n_o = !rd;
    wr_n_o = rd;
    wdata_o = b;
    repeat (3) @(negedge clk_i);
    r = rdata_i;  // registered read data has settled by now
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    cs_n_o = 1'b1;
    wdata_o = ~b;  // released lines must not keep looking valid
  endtask
  // poll status until busy clears; bounded so a stuck flag cannot hang
  task automatic wait_ready();
    logic [7:0] st;
    st = 8'h01;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 800 && st[0] !== 1'b0; i++) begin
      strobe(1'b1, 1'b0, 8'h00, st);
    end
    if (st[0] !== 1'b0) stuck = 1'b1;
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [7:0] r;
    wait_ready();
    strobe(1'b0, 1'b0, c, r);
  endtask
  // a data word always moves high byte first
  task automatic wr_word(input logic [15:0] w);
    logic [7:0] r;
    wait_ready();
    strobe(1'b0, 1'b1, w[15:8], r);
    strobe(1'b0, 1'b1, w[7:0], r);
  endtask
  task automatic rd_word(output logic [15:0] w);
    wait_ready();
    strobe(1'b1, 1'b1, 8'h00, w[15:8]);
    strobe(1'b1, 1'b1, 8'h00, w[7:0]);
  endtask
endmodule
`default_nettype wire

// file: tb/motion_profile_output_host_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motion_profile_output_host_port_bench;
  import mpo_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n, rd_n, wr_n, ps_n, oe, tick, sel, stb_n, sgn, mag, steady;
  logic stb_prev = 1'b1;
  logic [7:0] hd_w, hd_r, dac, st;
  logic [11:0] drive = 12'h000;
  logic [11:0] off;
  logic [11:0] tab[4] = '{12'h7F0, 12'h800, 12'hFF5, 12'h010};
  logic [31:0] dpos, tgt, p1;
  logic [15:0] w;
  logic [8:0] cap_q[$];
  longint cyc = 0;
  longint pacc, vacc, t0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n, hi, d;

  mpo_core dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .port_select_n_i(ps_n), .host_data_i(hd_w), .host_data_o(hd_r), .host_data_oe_o(oe),
    .drive_i(drive), .desired_pos_o(dpos), .sample_tick_o(tick), .dac_data_o(dac),
    .dac_word_sel_o(sel), .dac_strobe_n_o(stb_n), .pwm_sign_o(sgn), .pwm_mag_o(mag)
  );
  mpo_host_model hu (
    .clk_i(clk_i), .rdata_i(hd_r), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .port_select_n_o(ps_n), .wdata_o(hd_w)
  );

  // clock and a cycle count for busy timing
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
  end
  // external latch: takes the word as the strobe rises
  always @(negedge clk_i) begin
    stb_prev <= stb_n;
    if (stb_n === 1'b1 && stb_prev === 1'b0) cap_q.push_back({sel, dac});
  end
  always @(posedge hu.stuck) begin
    check(1'b0, "host never saw busy clear");
    tally_and_finish();
  end

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // single place where the run ends
  task automatic tally_and_finish();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // run to the next tick, counting cycles, pwm high time and dac changes
  task automatic wait_tick();
    logic [7:0] d0;
    n = 0;
    hi = 0;
    steady = 1'b1;
    d0 = dac;
    while (tick !== 1'b1) begin
      @(negedge clk_i);
      n++;
      hi += int'(mag === 1'b1);
      steady &= (dac === d0);
      if (n > 2100) begin
        check(1'b0, "sample tick missing");
        tally_and_finish();
      end
    end
    @(negedge clk_i);
  endtask
  // profile registers update at the tick; allow two cycles to land
  task automatic step();
    wait_tick();
    repeat (2) @(negedge clk_i);
  endtask
  // last pair goes out just after a tick so the first profile step is known
  task automatic load_trajectory_cmd(input logic [15:0] ctrl, input logic [31:0] acc,
                      input logic [31:0] vel, input logic [31:0] pos);
    logic [15:0] q[$];
    q = {ctrl};
    if (ctrl[TC_LD_ACC]) q = {q, acc[31:16], acc[15:0]};
    if (ctrl[TC_LD_VEL]) q = {q, vel[31:16], vel[15:0]};
    if (ctrl[TC_LD_POS]) q = {q, pos[31:16], pos[15:0]};
    hu.cmd(LOAD_TRAJECTORY_CMD);
    foreach (q[i]) begin
      if (i == q.size() - 1) begin
        hu.wait_ready();
        wait_tick();
      end
      hu.wr_word(q[i]);
    end
    hu.wait_ready();
  endtask

  initial begin
    void'($urandom(32'h2BA80156));
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check(dac === DAC8_ZERO && stb_n === 1'b1 && sel === 1'b0, "dac reset");
    check(mag === 1'b0 && dpos === 32'h0, "motor and position reset");
    hu.strobe(1'b1, 1'b0, 8'h00, st);
    check(st === 8'h00, "status after reset");
    // motor starts off: zero code whatever the drive asks
    drive = 12'($urandom);
    wait_tick();
    wait_tick();
    check(dac === DAC8_ZERO && hi == 0, "motor off output");
    // busy holds its time; a command sent meanwhile is dropped
    hu.cmd(CLEAR_WRAP_CMD);
    t0 = cyc;
    hu.strobe(1'b1, 1'b0, 8'h00, st);
    check(st === 8'h01, "busy after command");
    repeat (1000) @(negedge clk_i);
    hu.strobe(1'b0, 1'b0, TWELVE_BIT_PORT_CMD, st);
    hu.wait_ready();
    check(cyc - t0 > 2900 && cyc - t0 < 3100, "busy hold time");
    load_trajectory_cmd(16'h0000, 32'h0, 32'h0, 32'h0);
    // 8-bit word and pwm duty for each drive level
    for (int k = 0; k < 5; k++) begin
      drive = (k < 4) ? tab[k] : 12'($urandom);
      d = int'($signed(drive[11:4]));
      wait_tick();
      check(dac === (drive[11:4] ^ DAC8_ZERO), "8-bit dac word");
      wait_tick();
      check(n == 2047 && steady === 1'b1, "sample period or held word");
      hi = hi - 16 * (d < 0 ? -d : d);
      check(hi inside {[-1:1]} && sgn === drive[11], "pwm duty or sign");
    end
    // velocity mode: 1.5 per sample up to 3.0, then steady
    load_trajectory_cmd(16'h1828, 32'h0001_8000, 32'h0003_0000, 32'h0);
    pacc = 0;
    vacc = 0;
    for (int s = 0; s < 4; s++) begin
      step();
      vacc = (vacc + 64'h1_8000 > 64'h3_0000) ? 64'h3_0000 : vacc + 64'h1_8000;
      pacc += vacc;
      check(dpos === 32'(pacc >>> 16), "velocity mode position");
    end
    // smooth stop: the position must come to rest
    load_trajectory_cmd(16'h0400, 32'h0, 32'h0, 32'h0);
    repeat (3) step();
    p1 = dpos;
    step();
    check(dpos === p1, "rest after stop");
    // position move with the held rates
    tgt = dpos + 32'h10;
    load_trajectory_cmd(16'h0002, 32'h0, 32'h0, tgt);
    for (int s = 0; s < 12 && dpos !== tgt; s++) begin
      step();
      check($signed(dpos) <= $signed(tgt), "overshoot");
    end
    step();
    check(dpos === tgt, "move end");
    hu.cmd(READ_DESIRED_POS_CMD);
    hu.rd_word(w);
    check(w === tgt[31:16], "position high word");
    hu.rd_word(w);
    check(w === tgt[15:0], "position low word");
    // twelve-bit port: low six bits then high six, each on a strobe rise
    check(cap_q.size() == 0, "strobe in 8-bit mode");
    hu.cmd(TWELVE_BIT_PORT_CMD);
    hu.wait_ready();
    drive = 12'($urandom);
    off = drive ^ DAC12_ZERO;
    wait_tick();
    cap_q.delete();
    repeat (30) @(negedge clk_i);
    check(cap_q.size() == 2 && cap_q[0] === {3'b000, off[5:0]}, "low word");
    check(cap_q[1] === {3'b100, off[11:6]}, "high word");
    tally_and_finish();
  end
endmodule
`default_nettype wire
